// *** hdl/lpd_consts.vh ***
// constants for the page-1 write-back destination address register
`ifndef LPD_CONSTS_VH
`define LPD_CONSTS_VH
// register byte offsets
`define LPD_OFS_DEST_BASE 12'h000
`define LPD_OFS_CTRL 12'h004
`define LPD_OFS_STATUS 12'h008
// destination base register fields
`define LPD_BASE_HI 28
`define LPD_BASE_LO 10
`define LPD_SEL_HI 5
`define LPD_SEL_LO 0
`define LPD_WMASK 32'h1FFFFC3F
// control register fields
`define LPD_CTRL_XLAT 0
`define LPD_CTRL_PROT 1
`define LPD_CTRL_MASK 32'h00000003
// status register fields
`define LPD_ST_BUSY 0
`define LPD_ST_SELBAD 1
`define LPD_ST_REGUSE 2
// widths
`define LPD_PA_W 29
`define LPD_SEL_W 6
`endif

// *** hdl/lpd_addr_gen.v ***
// destination physical address generator for page-1 write-back
`timescale 1ns/1ns
module lpd_addr_gen (
    // configuration
    input wire [18:0] baseField,
    input wire [5:0] bitSelect,
    input wire regInEffect,
    input wire [28:0] tlbAddr,
    // operand
    input wire [31:0] operandAddr,
    // result
    output reg [28:0] destAddr,
    output wire selectLegal
);
`include "lpd_consts.vh"

    // legal select patterns: ones contiguous from the top
    function legal_sel;
        input [5:0] s;
        begin
            legal_sel = (s == 6'h3F) || (s == 6'h3E) || (s == 6'h3C) ||
                (s == 6'h38) || (s == 6'h30) || (s == 6'h20) ||
                (s == 6'h00);
        end
    endfunction

    assign selectLegal = legal_sel(bitSelect);

    // address assembly
    always @* begin
        if (regInEffect) begin // see R1
            destAddr[28:16] = baseField[18:6]; // see R10
            // per-bit choice, 1 takes stored base
            destAddr[15:10] = (bitSelect & baseField[5:0]) |
                (~bitSelect & operandAddr[15:10]); // see R4 see R5 see R6
        end else begin
            destAddr[28:10] = tlbAddr[28:10];
        end
        destAddr[9:5] = operandAddr[9:5]; // see R8
        destAddr[4:0] = 5'h00; // see R8
    end
endmodule // lpd_addr_gen

// *** hdl/lpd_dest_reg.v ***
// page-1 write-back destination register with APB slave
// Function
// R1 - register gives destination only with translation off or protection off
// R2 - bits 31..29 and 9..6 read zero, writes ignored
// R3 - bits 28..10 hold destination base, read-write, undefined at reset
// R4 - bits 5..0 select per address bit 15..10
// R5 - each select bit picks operand or stored base bit
// R6 - select patterns set granularity from 1 to 64 Kbytes
// R7 - software writes only the seven legal select patterns
// R8 - address bits 9..5 from operand, bits 4..0 zero
// R9 - write-back to local memory starts block transfer at that address
// R10 - bits 28..16 always from stored base while register applies
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ns
module lpd_dest_reg (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // write-back instruction request
    input wire wbReq,
    input wire [31:0] wbOperandAddr,
    input wire [28:0] wbTlbAddr,
    output wire wbReqReady,
    // transfer engine side
    output reg xferStart,
    output reg [28:0] xferDestAddr,
    input wire xferDone
);
`include "lpd_consts.vh"

    // register state
    reg [31:0] destBase_ff;
    reg [1:0] ctrl_ff;
    reg busy_ff;

    // next values of the registers
    reg [31:0] nxt_destBase;
    reg [1:0] nxt_ctrl;
    reg [31:0] nxt_prdata;
    reg nxt_busy;
    reg nxt_xferStart;
    reg [28:0] nxt_xferDestAddr;

    // decode nets
    wire wrEn;
    wire rdSetup;
    wire hitBase;
    wire hitCtrl;
    wire hitStat;
    wire hitAny;

    // datapath nets
    wire regInEffect;
    wire [28:0] genAddr;
    wire selLegal;
    wire startNow;
    wire [31:0] baseWord;
    wire [31:0] ctrlWord;
    wire [31:0] statusWord;

    // true when the bus address matches one register offset
    function offset_hit;
        input [11:0] addr;
        input [11:0] offset;
        begin
            offset_hit = (addr == offset);
        end
    endfunction

    // zero wait states: every access phase completes at once
    assign pready = 1'b1;

    // write lands in the access phase, read data fetched in setup
    assign wrEn = psel & penable & pwrite;
    assign rdSetup = psel & ~penable & ~pwrite;

    // offset decode shared by write, read and error paths
    assign hitBase = offset_hit(paddr, `LPD_OFS_DEST_BASE);
    assign hitCtrl = offset_hit(paddr, `LPD_OFS_CTRL);
    assign hitStat = offset_hit(paddr, `LPD_OFS_STATUS);
    assign hitAny = hitBase | hitCtrl | hitStat;

    // unmapped offsets answer with an error, writes dropped
    assign pslverr = psel & penable & ~hitAny;

    // register applies when translation or protection is off
    assign regInEffect = ~ctrl_ff[`LPD_CTRL_XLAT] |
        ~ctrl_ff[`LPD_CTRL_PROT]; // see R1

    // readable words, reserved bits forced to zero
    assign baseWord = destBase_ff & `LPD_WMASK; // see R2
    assign ctrlWord = {30'h00000000, ctrl_ff};
    assign statusWord = {29'h00000000, regInEffect, ~selLegal, busy_ff};

    // writable bits only; reserved bits kept zero
    always @* begin
        nxt_destBase = destBase_ff;
        if (wrEn && hitBase) begin
            nxt_destBase = pwdata & `LPD_WMASK; // see R2 see R3 see R4
        end
    end

    // base register: contents undefined, data path not reset
    always @(posedge clk) begin
        destBase_ff <= nxt_destBase; // see R3
    end

    // control word: translation and protection enables
    always @* begin
        nxt_ctrl = ctrl_ff;
        if (wrEn && hitCtrl) begin
            nxt_ctrl = pwdata[1:0];
        end
    end

    // control register, cleared so the register applies after reset
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= 2'h0;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // read mux, loaded in setup so data stands in the access phase
    always @* begin
        nxt_prdata = prdata;
        if (rdSetup) begin
            if (hitBase) begin
                nxt_prdata = baseWord; // see R2
            end else if (hitCtrl) begin
                nxt_prdata = ctrlWord;
            end else if (hitStat) begin
                nxt_prdata = statusWord;
            end else begin
                nxt_prdata = 32'h00000000;
            end
        end
    end

    // read data register, holds between reads
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= nxt_prdata;
        end
    end

    // address generator: stored base, select field, operand
    lpd_addr_gen u_gen (
        .baseField(destBase_ff[`LPD_BASE_HI:`LPD_BASE_LO]),
        .bitSelect(destBase_ff[`LPD_SEL_HI:`LPD_SEL_LO]),
        .regInEffect(regInEffect),
        .tlbAddr(wbTlbAddr),
        .operandAddr(wbOperandAddr),
        .destAddr(genAddr),
        .selectLegal(selLegal)
    );

    // one transfer in flight; further requests refused while busy
    assign wbReqReady = ~busy_ff;
    assign startNow = wbReq & ~busy_ff;

    // next transfer state; a new start wins over a late done
    always @* begin
        nxt_xferStart = startNow; // see R9
        nxt_xferDestAddr = xferDestAddr;
        nxt_busy = busy_ff;
        if (startNow) begin
            nxt_xferDestAddr = genAddr; // see R9
            nxt_busy = 1'b1;
        end else if (xferDone) begin
            nxt_busy = 1'b0;
        end
    end

    // launch one block transfer per accepted write-back
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_ff <= 1'b0;
            xferStart <= 1'b0;
            xferDestAddr <= 29'h00000000;
        end else begin
            busy_ff <= nxt_busy;
            xferStart <= nxt_xferStart;
            xferDestAddr <= nxt_xferDestAddr;
        end
    end

    // the address handed over stands until the next start, so the
    // engine may sample it any time while the transfer runs; an
    // illegal select pattern is not blocked here, it is only
    // flagged in the status word for software to notice
    // the translated address path is chosen inside the generator,
    // so the engine never needs to know which source applied
    // the base register has no reset: software must write it
    // before the first write-back that relies on it
endmodule // lpd_dest_reg

// *** tb/lpd_dest_reg_chk.sv ***
// port assertions for the page-1 destination register
`timescale 1ns/1ns
module lpd_dest_reg_chk (
    // clock, reset and apb
    input wire clk, reset_n, psel, penable, pwrite, pslverr,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    // write-back side
    input wire wbReq, wbReqReady, xferStart,
    input wire [31:0] wbOperandAddr,
    input wire [28:0] xferDestAddr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // helper terms
    wire acc = psel && penable;
    wire mapd = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
    wire [4:0] opMid = wbOperandAddr[9:5];
    a_err_unmapped: assert property (pslverr == (acc && !mapd))
        else $error("pslverr");
    a_rsvd_zero: assert property (psel && !penable && !pwrite &&
        paddr == 12'h000 |=> prdata[31:29] == 3'h0 && prdata[9:6] == 4'h0)
        else $error("reserved");
    a_start_take: assert property (wbReq && wbReqReady |=> xferStart)
        else $error("no start");
    a_start_cause: assert property (xferStart |-> $past(wbReq))
        else $error("stray start");
    a_start_pulse: assert property (xferStart |=> !xferStart)
        else $error("long start");
    a_busy_refuse: assert property (xferStart |-> !wbReqReady)
        else $error("ready busy");
    a_low_zero: assert property (xferStart |-> !xferDestAddr[4:0])
        else $error("low bits");
    a_mid_operand: assert property (xferStart |->
        xferDestAddr[9:5] == $past(opMid)) else $error("mid bits");
    cover property (xferStart);
    cover property (acc && pslverr);
    cover property (acc && !pwrite && paddr == 12'h000);
endmodule // lpd_dest_reg_chk
bind lpd_dest_reg lpd_dest_reg_chk chk (.*);

// *** tb/tb_lpd_dest_reg.sv ***
// self-checking bench for the page-1 destination register
`timescale 1ns/1ns
module tb_lpd_dest_reg;
    reg clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    reg wbReq = 0, xferDone = 0, er;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0, wbOperandAddr = 0, rd, e, b;
    reg [31:0] o = 32'hFFFF57FF;
    reg [28:0] wbTlbAddr = 29'h0ABCDC00;
    reg [5:0] s;
    wire pready, pslverr, wbReqReady, xferStart;
    wire [31:0] prdata;
    wire [28:0] xferDestAddr;
    integer failures = 0, comparisons = 0, cyc = 0, i;
    lpd_dest_reg uut (.*);
    // clock and hang limit
    initial forever #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            tally_and_finish;
        end
    end
    // compare and count
    task chk(input string n, input [31:0] v, x);
        comparisons++;
        if (v !== x) begin
            failures++;
            $display("wrong value %s exp %h got %h", n, x, v);
        end
    endtask
    // one apb transfer
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // one write-back request, then engine done
    task wb;
        @(posedge clk);
        wbReq <= 1;
        wbOperandAddr <= o;
        do @(posedge clk); while (wbReqReady !== 1);
        wbReq <= 0;
        @(negedge clk);
        chk("start", xferStart, 1);
        chk("refuse", wbReqReady, 0);
        chk("dest", xferDestAddr, e);
        @(posedge clk);
        xferDone <= 1;
        @(posedge clk);
        xferDone <= 0;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1;
        apb(1, 0, 32'hFFFFFFFF);
        chk("pready", pready, 1);
        apb(0, 0, 0);
        chk("base", rd, 32'h1FFFFC3F);
        apb(0, 12'h008, 0);
        chk("status", rd, 32'h00000004);
        apb(1, 0, 32'h00000015);
        apb(0, 12'h008, 0);
        chk("selbad", rd, 32'h00000006);
        apb(1, 12'h00C, 32'hFFFFFFFF);
        chk("werr", er, 1);
        apb(0, 12'h00C, 0);
        chk("err", {rd[0], er}, 1);
        for (i = 0; i < 7; i++) begin
            s = 6'h3F << i;
            b = 32'h1234A800 | s;
            apb(1, 0, b);
            e = {b[28:16], s & b[15:10] | ~s & o[15:10], o[9:5], 5'h00};
            wb;
        end
        apb(1, 12'h004, 3);
        apb(0, 12'h004, 0);
        chk("ctrl", rd, 3);
        apb(0, 12'h008, 0);
        chk("status off", rd, 0);
        e = {wbTlbAddr[28:10], o[9:5], 5'h00};
        wb;
        tally_and_finish;
    end
endmodule // tb_lpd_dest_reg
